/* rtl/audio_route_mon_pkg.sv */
// constants shared by the audio routing and clock monitor block
package audio_route_mon_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_ROUTE = 8'h35;
  localparam logic [7:0] ADDR_RATE_MON = 8'h37;
  localparam logic [7:0] ADDR_RATIO_MON = 8'h38;
  localparam logic [7:0] ADDR_FLAGS = 8'h39;
  localparam logic [7:0] ADDR_VOLUME = 8'h4c;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ROUTE_RST = 8'h11;
  localparam logic [7:0] MON_RST = 8'h00;
  localparam logic [7:0] VOLUME_RST = 8'h30;
  localparam logic [7:0] VOLUME_MUTE = 8'hff;
  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int LEFT_SEL_LSB = 4;
  localparam int RIGHT_SEL_LSB = 0;
  localparam int RSVD_LSB = 6;
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] SEL_OWN = 2'h1;
  localparam logic [1:0] SEL_OTHER = 2'h2;
  localparam int FLAG_BCK_RATE = 5;
  localparam int FLAG_PLL_OVER = 4;
  localparam int FLAG_PLL_UNLOCK = 3;
  localparam int FLAG_BCK_MISSING = 2;
  localparam int FLAG_BCK_INVALID = 1;
  localparam int FLAG_RATE_ERR = 0;
  localparam logic [3:0] RATE_ERR = 4'h0;
  localparam logic [3:0] RATE_8K = 4'h2;
  localparam logic [3:0] RATE_16K = 4'h4;
  localparam logic [3:0] RATE_32K = 4'h6;
  localparam logic [3:0] RATE_48K = 4'h9;
  localparam logic [3:0] RATE_96K = 4'hb;
  localparam logic [9:0] RATIO_MIN = 10'h020;
  localparam logic [9:0] RATIO_MAX = 10'h200;
  localparam logic [9:0] RATIO_SAT = 10'h3ff;
  // ----------------------------------------
  // data path and timing
  // ----------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam logic [11:0] PER_8K = 12'(SYS_CLK_HZ / 8_000);
  localparam logic [11:0] PER_16K = 12'(SYS_CLK_HZ / 16_000);
  localparam logic [11:0] PER_32K = 12'(SYS_CLK_HZ / 32_000);
  localparam logic [11:0] PER_48K = 12'(SYS_CLK_HZ / 48_000);
  localparam logic [11:0] PER_96K = 12'(SYS_CLK_HZ / 96_000);
  localparam int BCK_MISSING_US = 150;
  localparam logic [11:0] BCK_MISSING_CYC = 12'(BCK_MISSING_US * (SYS_CLK_HZ / 1_000_000));
endpackage

/* rtl/sample_fifo.sv */
// synchronous sample fifo with registered read data
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  wire push = i_in_valid && o_in_ready;
  wire load = (count_r != '0) && (!out_valid_r || i_out_ready);
  assign o_in_ready = (count_r != (AW + 1)'(DEPTH));
  assign o_out_valid = out_valid_r;
  assign o_out_data = out_data_r;

  // storage has no reset; pointers, count and the read stage do
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers and occupancy of the storage array
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (load) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(load);
    end
  end

  // read stage register, refilled when empty or taken
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem_r[rd_ptr_r];
    end else if (i_out_ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule

/* rtl/audio_route_mon.sv */
// serial audio input routing and clock monitor
`timescale 1ns/100ps
module audio_route_mon (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_bit_clock,
  input wire logic i_frame_clk,
  input wire logic i_serial_data,
  input wire logic i_pll_enable,
  input wire logic i_pll_locked,
  input wire logic i_pll_overrate,
  input wire logic [3:0] i_rate_mode,
  input wire logic i_rate_err_ignore,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic [23:0] o_left_sample,
  output logic [23:0] o_right_sample,
  output logic o_sample_valid,
  input wire logic i_sample_ready,
  output logic [7:0] o_volume_level_code,
  output logic o_fifo_overrun
);
  localparam int SW = audio_route_mon_pkg::SAMPLE_W;

  // ----------------------------------------
  // link domain, clocked by the serial bit clock
  // ----------------------------------------
  logic lrst_s1_r, lrst_s2_r;
  logic lfr_s1_r, lfr_s2_r, lfr_d_r;
  logic ldat_s1_r, ldat_s2_r;
  logic [SW-1:0] lshift_r, lleft_r, lpay_left_r, lpay_right_r;
  logic [9:0] lbits_r, lpay_ratio_r;
  logic lpay_stable_r, ltoggle_r;

  // reset and pins enter the link domain through two flops
  always_ff @(posedge i_serial_bit_clock) begin
    lrst_s1_r <= i_rst_n;
    lrst_s2_r <= lrst_s1_r;
    lfr_s1_r <= i_frame_clk;
    lfr_s2_r <= lfr_s1_r;
    ldat_s1_r <= i_serial_data;
    ldat_s2_r <= ldat_s1_r;
  end

  wire lframe_start = lfr_d_r && !lfr_s2_r;
  wire lhalf_start = !lfr_d_r && lfr_s2_r;
  wire [9:0] lbits_inc = (lbits_r == audio_route_mon_pkg::RATIO_SAT) ? lbits_r : lbits_r + 10'h001;

  // bit count per frame; the last bits of each half are the word
  always_ff @(posedge i_serial_bit_clock) begin
    if (!lrst_s2_r) begin
      lfr_d_r <= 1'b0;
      lshift_r <= '0;
      lleft_r <= '0;
      lbits_r <= '0;
    end else begin
      lfr_d_r <= lfr_s2_r;
      lshift_r <= {lshift_r[SW-2:0], ldat_s2_r};
      if (lhalf_start) lleft_r <= lshift_r;
      lbits_r <= lframe_start ? 10'h000 : lbits_inc;
    end
  end

  // payload stays still for a whole frame, far longer than the crossing
  always_ff @(posedge i_serial_bit_clock) begin
    if (!lrst_s2_r) begin
      lpay_left_r <= '0;
      lpay_right_r <= '0;
      lpay_ratio_r <= '0;
      lpay_stable_r <= 1'b0;
      ltoggle_r <= 1'b0;
    end else if (lframe_start) begin
      lpay_left_r <= lleft_r;
      lpay_right_r <= lshift_r;
      lpay_ratio_r <= lbits_inc;
      lpay_stable_r <= (lbits_inc == lpay_ratio_r);
      ltoggle_r <= !ltoggle_r;
    end
  end

  // ----------------------------------------
  // crossing into the system clock
  // ----------------------------------------
  logic tg_s1_r, tg_s2_r, tg_s3_r;
  logic pen_s1_r, pen_s2_r, plk_s1_r, plk_s2_r, pov_s1_r, pov_s2_r;

  // pll levels pass two flops before use
  always_ff @(posedge i_clk) begin
    pen_s1_r <= i_pll_enable;
    pen_s2_r <= pen_s1_r;
    plk_s1_r <= i_pll_locked;
    plk_s2_r <= plk_s1_r;
    pov_s1_r <= i_pll_overrate;
    pov_s2_r <= pov_s1_r;
  end

  // toggle flops clear in reset so no unknown or false frame event follows it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end else begin
      tg_s1_r <= ltoggle_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  wire frame_evt = tg_s2_r ^ tg_s3_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] route_r, rate_rsvd_r, flag_rsvd_r, volume_r;
  wire wr_route = i_reg_wr && (i_reg_addr == audio_route_mon_pkg::ADDR_ROUTE);
  wire wr_rate = i_reg_wr && (i_reg_addr == audio_route_mon_pkg::ADDR_RATE_MON);
  wire wr_flag = i_reg_wr && (i_reg_addr == audio_route_mon_pkg::ADDR_FLAGS);
  wire wr_vol = i_reg_wr && (i_reg_addr == audio_route_mon_pkg::ADDR_VOLUME);

  // only writable bits are stored; monitor fields ignore writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      route_r <= audio_route_mon_pkg::ROUTE_RST;
      rate_rsvd_r <= audio_route_mon_pkg::MON_RST;
      flag_rsvd_r <= audio_route_mon_pkg::MON_RST;
      volume_r <= audio_route_mon_pkg::VOLUME_RST;
    end else begin
      if (wr_route) route_r <= i_reg_wdata & 8'hff;
      if (wr_rate) rate_rsvd_r <= {i_reg_wdata[7:6], 6'h00};
      if (wr_flag) flag_rsvd_r <= {i_reg_wdata[7:6], 6'h00};
      if (wr_vol) volume_r <= i_reg_wdata;
    end
  end

  // ----------------------------------------
  // monitor: ratio, period, rate code
  // ----------------------------------------
  logic [9:0] ratio_r;
  logic ratio_stable_r;
  logic [11:0] per_cnt_r, period_r;
  logic [3:0] rate_code_r;
  logic [5:0] flags_r;

  wire missing = (per_cnt_r >= audio_route_mon_pkg::BCK_MISSING_CYC);
  wire [11:0] per_inc = (per_cnt_r == 12'hfff) ? per_cnt_r : per_cnt_r + 12'h001;

  // period in system cycles between frame events, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      per_cnt_r <= '0;
      period_r <= '0;
      ratio_r <= '0;
      ratio_stable_r <= 1'b0;
    end else if (frame_evt) begin
      per_cnt_r <= '0;
      period_r <= per_inc;
      ratio_r <= lpay_ratio_r;
      ratio_stable_r <= lpay_stable_r;
    end else begin
      per_cnt_r <= per_inc;
      if (missing) ratio_r <= '0;
      if (missing) ratio_stable_r <= 1'b0;
    end
  end

  // window of one sixteenth around a nominal frame period
  function automatic logic in_win(input logic [11:0] p, input logic [11:0] nom);
    logic [12:0] lo, hi;
    lo = {1'b0, nom} - {5'h00, nom[11:4]};
    hi = {1'b0, nom} + {5'h00, nom[11:4]};
    return ({1'b0, p} >= lo) && ({1'b0, p} <= hi);
  endfunction

  wire [3:0] rate_code_nxt =
    missing ? audio_route_mon_pkg::RATE_ERR :
    in_win(period_r, audio_route_mon_pkg::PER_8K) ? audio_route_mon_pkg::RATE_8K :
    in_win(period_r, audio_route_mon_pkg::PER_16K) ? audio_route_mon_pkg::RATE_16K :
    in_win(period_r, audio_route_mon_pkg::PER_32K) ? audio_route_mon_pkg::RATE_32K :
    in_win(period_r, audio_route_mon_pkg::PER_48K) ? audio_route_mon_pkg::RATE_48K :
    in_win(period_r, audio_route_mon_pkg::PER_96K) ? audio_route_mon_pkg::RATE_96K :
    audio_route_mon_pkg::RATE_ERR;

  // error-high flags; all recomputed every cycle, none latch
  wire ratio_in_range = (ratio_r >= audio_route_mon_pkg::RATIO_MIN) &&
    (ratio_r <= audio_route_mon_pkg::RATIO_MAX);
  wire rate_err = (i_rate_mode == 4'h0) ?
    (rate_code_nxt == audio_route_mon_pkg::RATE_ERR) : (rate_code_nxt != i_rate_mode);
  wire [5:0] flags_nxt = {
    !missing && !ratio_in_range,
    pen_s2_r && pov_s2_r,
    !(pen_s2_r && plk_s2_r),
    missing,
    missing || !ratio_stable_r || !ratio_in_range,
    rate_err
  };

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rate_code_r <= '0;
      flags_r <= '0;
    end else begin
      rate_code_r <= rate_code_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  logic [7:0] rdata_r;
  wire [7:0] rate_reg = {rate_rsvd_r[7:6], ratio_r[9:8], rate_code_r};
  wire [7:0] flag_reg = {flag_rsvd_r[7:6], flags_r};
  wire [7:0] rd_mux =
    (i_reg_addr == audio_route_mon_pkg::ADDR_ROUTE) ? route_r :
    (i_reg_addr == audio_route_mon_pkg::ADDR_RATE_MON) ? rate_reg :
    (i_reg_addr == audio_route_mon_pkg::ADDR_RATIO_MON) ? ratio_r[7:0] :
    (i_reg_addr == audio_route_mon_pkg::ADDR_FLAGS) ? flag_reg :
    (i_reg_addr == audio_route_mon_pkg::ADDR_VOLUME) ? volume_r : 8'h00;

  // unmapped offsets read as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) rdata_r <= '0;
    else if (i_reg_rd) rdata_r <= rd_mux;
  end

  // ----------------------------------------
  // sample fifo and routing
  // ----------------------------------------
  logic fifo_in_ready, fifo_out_valid, overrun_r;
  logic [2*SW-1:0] fifo_out_data;
  logic [SW-1:0] left_r, right_r;
  logic valid_r;

  // the serial source cannot wait, so a full fifo drops the frame
  sample_fifo #(
    .WIDTH(2 * SW),
    .DEPTH(audio_route_mon_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(frame_evt),
    .o_in_ready(fifo_in_ready),
    .i_in_data({lpay_left_r, lpay_right_r}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(!valid_r || i_sample_ready),
    .o_out_data(fifo_out_data)
  );

  wire pop = fifo_out_valid && (!valid_r || i_sample_ready);
  wire [SW-1:0] in_left = fifo_out_data[2*SW-1:SW];
  wire [SW-1:0] in_right = fifo_out_data[SW-1:0];
  wire [1:0] left_sel = route_r[audio_route_mon_pkg::LEFT_SEL_LSB +: 2];
  wire [1:0] right_sel = route_r[audio_route_mon_pkg::RIGHT_SEL_LSB +: 2];
  // a rate error mutes unless software chose to ignore it; pll and ratio faults do not mute
  wire mute_all = (volume_r == audio_route_mon_pkg::VOLUME_MUTE) ||
    (flags_r[audio_route_mon_pkg::FLAG_RATE_ERR] && !i_rate_err_ignore);
  // reserved code 11 falls into the zero branch
  wire [SW-1:0] left_nxt = mute_all ? '0 :
    (left_sel == audio_route_mon_pkg::SEL_OWN) ? in_left :
    (left_sel == audio_route_mon_pkg::SEL_OTHER) ? in_right : '0;
  wire [SW-1:0] right_nxt = mute_all ? '0 :
    (right_sel == audio_route_mon_pkg::SEL_OWN) ? in_right :
    (right_sel == audio_route_mon_pkg::SEL_OTHER) ? in_left : '0;

  // output stage holds a pair until the consumer takes it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      left_r <= '0;
      right_r <= '0;
      valid_r <= 1'b0;
    end else if (pop) begin
      left_r <= left_nxt;
      right_r <= right_nxt;
      valid_r <= 1'b1;
    end else if (i_sample_ready) begin
      valid_r <= 1'b0;
    end
  end

  // sticky until reset so a lost frame is never missed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) overrun_r <= 1'b0;
    else if (frame_evt && !fifo_in_ready) overrun_r <= 1'b1;
  end

  assign o_reg_rdata = rdata_r;
  assign o_left_sample = left_r;
  assign o_right_sample = right_r;
  assign o_sample_valid = valid_r;
  assign o_volume_level_code = volume_r;
  assign o_fifo_overrun = overrun_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_pop;
    pop && !mute_all;
  endsequence

  chk_route_reset: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> route_r == 8'h11)
    else $error("routing register not 0x11 after reset");
  chk_left_route: assert property (
    s_pop ##0 (left_sel == 2'h1) |=> left_r == $past(in_left))
    else $error("left output not fed from left input");
  chk_right_swap: assert property (
    s_pop ##0 (right_sel == 2'h2) |=> right_r == $past(in_left))
    else $error("right output not fed from left input");
  chk_reserved_sel: assert property (
    pop && (left_sel == 2'h3 || left_sel == 2'h0) |=> left_r == '0)
    else $error("zero or reserved selector passed data");
  chk_ratio_split: assert property (
    frame_evt ##1 !missing |-> {rate_reg[5:4], ratio_r[7:0]} == $past(lpay_ratio_r))
    else $error("ratio fields do not match measured ratio");
  chk_rate_flag: assert property (
    (i_rate_mode == 4'h0) && (rate_code_nxt == 4'h0) |=> flags_r[0])
    else $error("rate error flag hidden");
  chk_ignore_flag: assert property (
    i_rate_err_ignore && (i_rate_mode != 4'h0) && (rate_code_nxt != i_rate_mode) |=> flags_r[0])
    else $error("ignore setting hid rate mismatch flag");
  chk_missing_flag: assert property (
    !frame_evt [*4] ##0 (per_cnt_r >= 12'h0ea6) |=> flags_r[2] && rate_code_r == 4'h0)
    else $error("missing clock not flagged");
  chk_pll_unlock: assert property (
    !pen_s2_r |=> flags_r[3])
    else $error("disabled pll not shown unlocked");
  chk_bck_range: assert property (
    (ratio_r < 10'h020 || ratio_r > 10'h200) |=> flags_r[1])
    else $error("out of range ratio shown valid");
  chk_ro_write: assert property (
    i_reg_wr && (i_reg_addr == 8'h38) && !frame_evt && !missing |=> $stable(ratio_r))
    else $error("write changed read-only ratio");
endmodule

/* bench/host_audio_model.sv */
// host audio source model: gated bit clock, frame clock and serial data
`timescale 1ns/100ps
module host_audio_model (
  output logic o_serial_bit_clock,
  output logic o_frame_clk,
  output logic o_serial_data
);
  // idle: clock still, frame clock high so the next frame opens on a falling edge
  initial begin
    o_serial_bit_clock = 1'b0;
    o_frame_clk = 1'b1;
    o_serial_data = 1'b0;
  end

  // bare bit clocks with the frame clock idle; the link side needs them to clear its reset
  task automatic run_idle(input int n);
    o_frame_clk = 1'b1;
    repeat (n) begin
      #15 o_serial_bit_clock = 1'b1;
      #15 o_serial_bit_clock = 1'b0;
    end
  endtask

  // one frame of 2*half bit clocks, msb first, word in the last 24 bits of each half;
  // the clock then stands still until the frame period has run out
  task automatic send_frame(input logic [23:0] l, input logic [23:0] r, input int half,
                            input int period_ns);
    int idx;
    for (int i = 0; i < 2 * half; i++) begin
      idx = half - 1 - (i % half);
      o_frame_clk = (i >= half);
      o_serial_data = (idx < 24) ? ((i < half) ? l[idx] : r[idx]) : 1'b0;
      #15 o_serial_bit_clock = 1'b1;
      #15 o_serial_bit_clock = 1'b0;
    end
    // released line shows the inverse, so a stale bit never passes for data
    o_serial_data = ~o_serial_data;
    #(period_ns - 60 * half);
  endtask
endmodule

/* bench/audio_route_mon_tb.sv */
// self-checking bench for the audio routing and clock monitor
`timescale 1ns/100ps
module audio_route_mon_tb;
  logic i_clk, i_rst_n, pll_en, pll_lock, pll_over, ign, rd, wr, ready;
  logic serial_bit_clock, frm, sdat, svalid, ovr;
  logic [3:0] rate_mode;
  logic [7:0] addr, wdata, rdata, vol, d;
  logic [23:0] left, right, last_l, last_r;
  int miscompares, n_checks;
  int rx_cnt = 0;
  localparam logic [23:0] L = 24'ha5_c3f1;
  localparam logic [23:0] R = 24'h3c_5a0f;

  audio_route_mon i_audio_route_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_bit_clock(serial_bit_clock), .i_frame_clk(frm),
    .i_serial_data(sdat), .i_pll_enable(pll_en), .i_pll_locked(pll_lock),
    .i_pll_overrate(pll_over), .i_rate_mode(rate_mode), .i_rate_err_ignore(ign),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_left_sample(left), .o_right_sample(right),
    .o_sample_valid(svalid), .i_sample_ready(ready), .o_volume_level_code(vol),
    .o_fifo_overrun(ovr)
  );
  host_audio_model i_host_audio_model (
    .o_serial_bit_clock(serial_bit_clock), .o_frame_clk(frm), .o_serial_data(sdat)
  );

  // system clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // keep the last sample taken by the consumer
  always @(posedge i_clk) begin
    if (svalid === 1'b1 && ready === 1'b1) begin
      rx_cnt++;
      last_l <= left;
      last_r <= right;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask

  // read data is registered at the read edge and holds until the next read
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_clk);
    addr = a;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    @(negedge i_clk);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a, d);
    chk(d, e);
  endtask

  // n frames of the fixed pair; the bit clock phase is offset from the system clock
  task automatic burst(input int half, input int cyc, input int n, input bit want);
    int rx0;
    rx0 = rx_cnt;
    @(negedge i_clk);
    #7;
    repeat (n) i_host_audio_model.send_frame(L, R, half, cyc * 40);
    @(negedge i_clk);
    for (int k = 0; k < 100 && want && rx_cnt == rx0; k++) @(negedge i_clk);
    if (want && rx_cnt == rx0) begin
      miscompares++;
      $display("CHECK FAILED %0t no sample arrived", $time);
      close_out();
    end
  endtask

  function automatic logic [23:0] pick(input logic [1:0] s, input logic [23:0] own,
                                       input logic [23:0] oth);
    return (s == 2'h1) ? own : (s == 2'h2) ? oth : 24'h00_0000;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(8'h35, 8'h11);
    rd_chk(8'h37, 8'h00);
    rd_chk(8'h38, 8'h00);
    rd_chk(8'h4c, 8'h30);
    rd_chk(8'h20, 8'h00);
    chk(vol, 8'h30);
    chk(svalid, 1'b0);
  endtask

  task automatic t_ro_writes();
    wr_reg(8'h38, 8'hff);
    rd_chk(8'h38, 8'h00);
    wr_reg(8'h37, 8'hff);
    rd_chk(8'h37, 8'hc0);
    wr_reg(8'h39, 8'hc0);
    rd_reg(8'h39, d);
    chk(d[7:6], 2'h3);
    wr_reg(8'h37, 8'h00);
    wr_reg(8'h39, 8'h00);
  endtask

  task automatic t_pll();
    for (int i = 0; i < 8; i++) begin
      {pll_en, pll_lock, pll_over} = 3'(i);
      repeat (4) @(negedge i_clk);
      rd_reg(8'h39, d);
      chk(d[4], i[2] & i[0]);
      chk(d[3], !(i[2] & i[1]));
    end
    {pll_en, pll_lock, pll_over} = 3'b110;
  endtask

  task automatic t_rates();
    int per[6] = '{3125, 1562, 781, 520, 260, 1000};
    logic [3:0] code[6] = '{4'h2, 4'h4, 4'h6, 4'h9, 4'hb, 4'h0};
    for (int i = 0; i < 6; i++) begin
      burst(32, per[i], 3, 1);
      rd_chk(8'h37, {4'h0, code[i]});
      rd_chk(8'h38, 8'h40);
      rd_reg(8'h39, d);
      chk(d[0], code[i] == 4'h0);
    end
  endtask

  task automatic t_route();
    logic [7:0] rt[7] = '{8'h11, 8'h22, 8'h12, 8'h21, 8'h00, 8'h10, 8'h02};
    for (int i = 0; i < 7; i++) begin
      // only the three defined selector codes are ever written
      wr_reg(8'h35, rt[i]);
      rd_chk(8'h35, rt[i]);
      burst(32, 520, 3, 1);
      chk(last_l, pick(rt[i][5:4], L, R));
      chk(last_r, pick(rt[i][1:0], R, L));
    end
    wr_reg(8'h35, 8'h11);
  endtask

  task automatic t_ignore();
    rate_mode = 4'h2;
    burst(32, 520, 3, 1);
    rd_reg(8'h39, d);
    chk(d[0], 1'b1);
    chk(last_l, 24'h00_0000);
    ign = 1'b1;
    burst(32, 520, 3, 1);
    rd_reg(8'h39, d);
    chk(d[0], 1'b1);
    chk(last_l, L);
    rate_mode = 4'h9;
    ign = 1'b0;
    burst(32, 520, 3, 1);
    rd_reg(8'h39, d);
    chk(d[0], 1'b0);
    rate_mode = 4'h0;
  endtask

  task automatic t_volume();
    wr_reg(8'h4c, 8'hff);
    @(negedge i_clk);
    chk(vol, 8'hff);
    burst(32, 520, 3, 1);
    chk(last_l, 24'h00_0000);
    chk(last_r, 24'h00_0000);
    wr_reg(8'h4c, 8'h30);
    @(negedge i_clk);
    chk(vol, 8'h30);
  endtask

  task automatic t_ratio();
    burst(256, 520, 3, 1);
    rd_chk(8'h37, 8'h29);
    rd_chk(8'h38, 8'h00);
    rd_chk(8'h39, 8'h00);
    burst(8, 520, 3, 0);
    rd_chk(8'h38, 8'h10);
    rd_reg(8'h39, d);
    chk(d[5], 1'b1);
    chk(d[1], 1'b1);
    repeat (3) begin
      burst(32, 520, 1, 0);
      burst(33, 520, 1, 0);
    end
    rd_reg(8'h39, d);
    chk(d[5], 1'b0);
    chk(d[1], 1'b1);
    repeat (3800) @(negedge i_clk);
    rd_reg(8'h39, d);
    chk(d[2], 1'b1);
    chk(d[1], 1'b1);
    burst(32, 520, 3, 1);
    rd_chk(8'h39, 8'h00);
  endtask

  // consumer stalls while frames keep coming, then drains everything
  task automatic t_overrun();
    int rx0;
    ready = 1'b0;
    rx0 = rx_cnt;
    burst(32, 260, 40, 0);
    chk(ovr, 1'b1);
    ready = 1'b1;
    for (int k = 0; k < 400 && rx_cnt - rx0 < 32; k++) @(negedge i_clk);
    chk(rx_cnt - rx0 >= 32, 1'b1);
    repeat (20) @(negedge i_clk);
    chk(svalid, 1'b0);
    chk(ovr, 1'b1);
  endtask

  // main sequence
  initial begin
    {i_rst_n, rd, wr, pll_over, ign} = '0;
    {pll_en, pll_lock, ready} = 3'b111;
    rate_mode = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    miscompares = 0;
    n_checks = 0;
    // the link side only leaves reset cleanly while the bit clock runs
    fork
      i_host_audio_model.run_idle(8);
    join_none
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_ro_writes();
    t_pll();
    t_rates();
    t_route();
    t_ignore();
    t_volume();
    t_ratio();
    t_overrun();
    close_out();
  end
endmodule
